// ### verilog/modbus_slave_defs.vh
// Operation
// - node address from five weighted switches, first switch is bit zero, range 0 to 31
// - addresses 32 to 255 come from a software-set address register
// - coil objects from 00001 use codes 1,5,15; discrete inputs from 10001 use 2
// - input registers from 30001 use code 3; holding registers from 40001 use 4,6,16
// - all stored data is 16-bit registers, reached by RTU or ASCII framing
// - factory setup is 19200 baud, no parity, 8 data, 1 stop, 0 ms, RTU
// - restore switch on at power-up loads factory setup and clears stored registers
// - rate codes 0..6 pick 2400..115200 baud, other values mean value times ten
// - parity codes: 0 none, 1 odd, 2 even, 3 forced zero, 4 forced one
// - one register holds stop-bit count and data-bit count
// - reply waits the response-delay register in milliseconds
// - mode register 0 selects RTU, 1 selects ASCII
// - watchdog times out in ms without valid frame and forces default outputs
// - watchdog value zero, the reset value, disables forcing
// - communication indicator lit while answering a correct frame
// - each output indicator lit while its output is on, one clock later
`ifndef MODBUS_SLAVE_DEFS_VH
`define MODBUS_SLAVE_DEFS_VH

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define IDX_VERSION      8'h00
`define IDX_SWITCHES     8'h01
`define IDX_RATE         8'h02
`define IDX_BITS         8'h03
`define IDX_PARITY       8'h04
`define IDX_DELAY        8'h05
`define IDX_MODE         8'h06
`define IDX_NODE_ADDR    8'h07
`define IDX_TIMEOUT      8'h08
`define IDX_DEF_OUT      8'h0C
`define IDX_OUTPUTS      8'h33

// ----------------------------------------------------------------
// function codes and reference bases
// ----------------------------------------------------------------
`define FC_RD_COILS      8'h01
`define FC_RD_INPUTS     8'h02
`define FC_RD_INREGS     8'h03
`define FC_RD_HOLDREGS   8'h04
`define FC_WR_COIL       8'h05
`define FC_WR_REG        8'h06
`define FC_WR_COILS      8'h0F
`define FC_WR_REGS       8'h10
`define REF_COIL         17'h00001
`define REF_INPUT        17'h02711
`define REF_INREG        17'h07531
`define REF_HOLDREG      17'h09C41

// ----------------------------------------------------------------
// factory values and encodings
// ----------------------------------------------------------------
`define RATE_DEFAULT     16'h0003
`define BAUD_DEFAULT     32'h00004B00
`define BITS_DEFAULT     16'h0108
`define PARITY_DEFAULT   16'h0000
`define DELAY_DEFAULT    16'h0000
`define MODE_DEFAULT     16'h0000
`define TIMEOUT_DEFAULT  16'h0000
`define ZERO16           16'h0000
`define DATA7            8'h07
`define STOP2            8'h02
`define MODE_ASCII       16'h0001
`define PAR_ODD          16'h0001
`define PAR_EVEN         16'h0002
`define PAR_ZERO         16'h0003
`define PAR_ONE          16'h0004
`define RATE_CODE_MAX    16'h0006
`define RATE_SCALE       10
`define CLK_HZ           20000000
`define MS_PER_S         1000
`define ADDR_SW_MAX      8'h1F

`endif

// ### verilog/ms_tick.v
`include "modbus_slave_defs.vh"

module ms_tick #(
    parameter CYCLES = 20000
) (
    // clock and reset
    input  wire clk,
    input  wire rst,
    // tick
    output reg  tick
);
    reg [31:0] count_reg;

    always @(posedge clk) begin
        if (rst) begin
            count_reg <= 32'h0;
            tick      <= 1'b0;
        end else if (count_reg == CYCLES - 1) begin
            count_reg <= 32'h0;
            tick      <= 1'b1;
        end else begin
            count_reg <= count_reg + 32'h1;
            tick      <= 1'b0;
        end
    end
endmodule // ms_tick

// ### verilog/modbus_slave_config_watchdog.v
`include "modbus_slave_defs.vh"

module modbus_slave_config_watchdog #(
    parameter MS_CYCLES = `CLK_HZ / `MS_PER_S,
    parameter VERSION   = 16'h0101      // arbitrary value
) (
    // clock and reset
    input  wire        clk,
    input  wire        rst,
    // switches, asynchronous pins
    input  wire        addr_switch_weight_1,
    input  wire        addr_switch_weight_2,
    input  wire        addr_switch_weight_4,
    input  wire        addr_switch_weight_8,
    input  wire        addr_switch_weight_16,
    input  wire        factory_restore_switch,
    // decoded request from frame engine
    input  wire        req_valid,
    input  wire [7:0]  req_node,
    input  wire [7:0]  req_func,
    input  wire [16:0] req_ref,
    input  wire [15:0] req_wdata,
    input  wire        frame_error,
    input  wire        reply_sent,
    // answer to frame engine
    output reg         rsp_valid,
    output reg  [15:0] rsp_rdata,
    output reg         rsp_exception,
    output reg         reply_go,
    // serial setup for the line engine
    output reg  [31:0] baud_rate,
    output reg  [2:0]  parity_mode,
    output reg         data_bits_8,
    output reg         stop_bits_2,
    output reg         ascii_mode,
    output reg  [7:0]  node_addr,
    // outputs and indicators
    output reg  [7:0]  outputs,
    output reg  [7:0]  output_led,
    output reg         comm_led,
    output reg         wdog_fired
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    wire [5:0] pins = {factory_restore_switch, addr_switch_weight_16, addr_switch_weight_8,
                       addr_switch_weight_4, addr_switch_weight_2, addr_switch_weight_1};
    reg  [5:0] s1_reg, s2_reg, s3_reg, sw_reg;
    always @(posedge clk) begin
        if (rst) begin
            s1_reg <= 6'h00;
            s2_reg <= 6'h00;
            s3_reg <= 6'h00;
            sw_reg <= 6'h00;
        end else begin
            s1_reg <= pins;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            sw_reg <= (s2_reg & s3_reg) | (sw_reg & (s2_reg | s3_reg));
        end
    end

    // ------------------------------------------------------------
    // millisecond tick
    // ------------------------------------------------------------
    wire ms;
    ms_tick #(.CYCLES(MS_CYCLES)) u_tick (
        .clk  (clk),
        .rst  (rst),
        .tick (ms)
    );

    // ------------------------------------------------------------
    // power-up sequence
    // ------------------------------------------------------------
    localparam ST_SETTLE = 3'b001;
    localparam ST_LOAD   = 3'b010;
    localparam ST_RUN    = 3'b100;
    reg [2:0] state_reg;
    reg [1:0] settle_reg;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    reg [15:0] serial_rate_select_reg;
    reg [15:0] frame_bit_counts_reg;
    reg [15:0] parity_select_reg;
    reg [15:0] reply_delay_ms_reg;
    reg [15:0] framing_mode_select_reg;
    reg [15:0] comm_timeout_ms_reg;

    reg [15:0] soft_addr_reg;
    reg [15:0] default_out_reg;
    reg [15:0] wdog_cnt_reg;
    reg [15:0] delay_cnt_reg;
    reg        replying_reg;

    // ------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------
    wire [7:0]  sw_addr  = {3'b000, sw_reg[4:0]};
    wire [7:0]  my_addr  = (soft_addr_reg[7:0] > `ADDR_SW_MAX) ?
                           soft_addr_reg[7:0] : sw_addr;
    wire        for_me   = req_valid && (req_node == my_addr) && (state_reg == ST_RUN);

    wire [16:0] off_coil = req_ref - `REF_COIL;
    wire [16:0] off_in   = req_ref - `REF_INPUT;
    wire [16:0] off_ir   = req_ref - `REF_INREG;
    wire [16:0] off_hr   = req_ref - `REF_HOLDREG;

    reg        r_ok;
    reg        w_reg;
    reg        w_coil;
    reg [7:0]  idx;
    reg [15:0] rd;

    always @* begin
        r_ok   = 1'b0;
        w_reg  = 1'b0;
        w_coil = 1'b0;
        idx    = off_hr[7:0];
        rd     = `ZERO16;

        case (req_func)
            `FC_RD_COILS, `FC_WR_COIL, `FC_WR_COILS: begin
                r_ok   = (off_coil < 17'h8);
                w_coil = r_ok && (req_func != `FC_RD_COILS);
                rd     = {15'h0, outputs[off_coil[2:0]]};
            end
            `FC_RD_INPUTS: begin
                r_ok = (off_in < 17'h6);
                rd   = {15'h0, sw_reg[off_in[2:0]]};
            end
            `FC_RD_INREGS: begin
                r_ok = (off_ir < 17'h2);
                rd   = off_ir[0] ? {10'h0, sw_reg} : VERSION;
            end
            `FC_RD_HOLDREGS, `FC_WR_REG, `FC_WR_REGS: begin
                r_ok  = (off_hr < 17'h100);
                w_reg = r_ok && (req_func != `FC_RD_HOLDREGS);
                case (idx)
                    `IDX_RATE:      rd = serial_rate_select_reg;
                    `IDX_BITS:      rd = frame_bit_counts_reg;
                    `IDX_PARITY:    rd = parity_select_reg;
                    `IDX_DELAY:     rd = reply_delay_ms_reg;
                    `IDX_MODE:      rd = framing_mode_select_reg;
                    `IDX_NODE_ADDR: rd = soft_addr_reg;
                    `IDX_TIMEOUT:   rd = comm_timeout_ms_reg;
                    `IDX_DEF_OUT:   rd = default_out_reg;
                    `IDX_OUTPUTS:   rd = {8'h00, outputs};
                    default:        rd = `ZERO16;
                endcase
            end
            default: r_ok = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // baud decode
    // ------------------------------------------------------------
    reg [31:0] rate_dec;
    always @* begin
        case (serial_rate_select_reg)
            16'h0000: rate_dec = 32'd2400;
            16'h0001: rate_dec = 32'd4800;
            16'h0002: rate_dec = 32'd9600;
            16'h0003: rate_dec = 32'd19200;
            16'h0004: rate_dec = 32'd38400;
            16'h0005: rate_dec = 32'd57600;
            16'h0006: rate_dec = 32'd115200;
            default:  rate_dec = {16'h0, serial_rate_select_reg} * `RATE_SCALE;
        endcase
    end

    // ------------------------------------------------------------
    // main sequential logic
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            state_reg               <= ST_SETTLE;
            settle_reg              <= 2'b00;

            serial_rate_select_reg  <= `RATE_DEFAULT;
            frame_bit_counts_reg    <= `BITS_DEFAULT;
            parity_select_reg       <= `PARITY_DEFAULT;
            reply_delay_ms_reg      <= `DELAY_DEFAULT;
            framing_mode_select_reg <= `MODE_DEFAULT;
            comm_timeout_ms_reg     <= `TIMEOUT_DEFAULT;

            soft_addr_reg           <= `ZERO16;
            default_out_reg         <= `ZERO16;
            wdog_cnt_reg            <= `ZERO16;
            delay_cnt_reg           <= `ZERO16;
            replying_reg            <= 1'b0;

            rsp_valid               <= 1'b0;
            rsp_rdata               <= `ZERO16;
            rsp_exception           <= 1'b0;
            reply_go                <= 1'b0;

            outputs                 <= 8'h00;
            output_led              <= 8'h00;
            comm_led                <= 1'b0;
            wdog_fired              <= 1'b0;

            baud_rate               <= `BAUD_DEFAULT;
            parity_mode             <= 3'b000;
            data_bits_8             <= 1'b1;
            stop_bits_2             <= 1'b0;
            ascii_mode              <= 1'b0;
            node_addr               <= 8'h00;
        end else begin
            rsp_valid <= 1'b0;
            reply_go  <= 1'b0;

            case (state_reg)
                ST_SETTLE: begin
                    // wait until the switch filters have filled
                    settle_reg <= settle_reg + 2'b01;
                    if (settle_reg == 2'b11)
                        state_reg <= ST_LOAD;
                end
                ST_LOAD: begin
                    if (sw_reg[5]) begin
                        serial_rate_select_reg  <= `RATE_DEFAULT;
                        frame_bit_counts_reg    <= `BITS_DEFAULT;
                        parity_select_reg       <= `PARITY_DEFAULT;
                        reply_delay_ms_reg      <= `DELAY_DEFAULT;
                        framing_mode_select_reg <= `MODE_DEFAULT;
                        comm_timeout_ms_reg     <= `TIMEOUT_DEFAULT;
                        soft_addr_reg           <= `ZERO16;
                        default_out_reg         <= `ZERO16;
                        outputs                 <= 8'h00;
                    end
                    state_reg <= ST_RUN;
                end
                ST_RUN: begin
                    if (for_me) begin
                        rsp_valid     <= 1'b1;
                        rsp_rdata     <= rd;
                        rsp_exception <= !r_ok;
                        replying_reg  <= 1'b1;
                        delay_cnt_reg <= reply_delay_ms_reg;
                        wdog_cnt_reg  <= comm_timeout_ms_reg;
                        wdog_fired    <= 1'b0;

                        if (w_coil)
                            outputs[off_coil[2:0]] <= req_wdata[0];
                        if (w_reg) begin
                            case (idx)
                                `IDX_RATE:      serial_rate_select_reg  <= req_wdata;
                                `IDX_BITS:      frame_bit_counts_reg    <= req_wdata;
                                `IDX_PARITY:    parity_select_reg       <= req_wdata;
                                `IDX_DELAY:     reply_delay_ms_reg      <= req_wdata;
                                `IDX_MODE:      framing_mode_select_reg <= req_wdata;
                                `IDX_NODE_ADDR: soft_addr_reg           <= req_wdata;
                                `IDX_TIMEOUT:   comm_timeout_ms_reg     <= req_wdata;
                                `IDX_DEF_OUT:   default_out_reg         <= req_wdata;
                                `IDX_OUTPUTS:   outputs                 <= req_wdata[7:0];
                                default:        rsp_exception           <= 1'b0;
                            endcase
                        end
                    end else begin
                        if (replying_reg) begin
                            if (delay_cnt_reg == `ZERO16)
                                reply_go <= !reply_go && !comm_led;
                            else if (ms)
                                delay_cnt_reg <= delay_cnt_reg - 16'h0001;
                            if (reply_sent)
                                replying_reg <= 1'b0;
                        end

                        if (comm_timeout_ms_reg == `ZERO16) begin
                            wdog_cnt_reg <= `ZERO16;
                        end else if (ms && wdog_cnt_reg != `ZERO16) begin
                            wdog_cnt_reg <= wdog_cnt_reg - 16'h0001;
                            if (wdog_cnt_reg == 16'h0001) begin
                                outputs    <= default_out_reg[7:0];
                                wdog_fired <= 1'b1;
                            end
                        end
                    end
                end
                default: state_reg <= ST_SETTLE;
            endcase

            comm_led    <= replying_reg && (delay_cnt_reg == `ZERO16) && !reply_sent;
            output_led  <= outputs;
            baud_rate   <= rate_dec;
            case (parity_select_reg)
                `PAR_ODD:  parity_mode <= 3'b001;
                `PAR_EVEN: parity_mode <= 3'b010;
                `PAR_ZERO: parity_mode <= 3'b011;
                `PAR_ONE:  parity_mode <= 3'b100;
                default:   parity_mode <= 3'b000;
            endcase

            data_bits_8 <= (frame_bit_counts_reg[7:0] != `DATA7);
            stop_bits_2 <= (frame_bit_counts_reg[15:8] == `STOP2);
            ascii_mode  <= (framing_mode_select_reg == `MODE_ASCII);
            node_addr   <= my_addr;
        end
    end
endmodule // modbus_slave_config_watchdog

// ### test/modbus_slave_config_watchdog_monitor.sv
module modbus_slave_config_watchdog_monitor (
    // clock and reset
    input wire        clk,
    input wire        rst,
    // request side
    input wire        req_valid,
    input wire [7:0]  req_node,
    input wire [7:0]  req_func,
    input wire [16:0] req_ref,
    input wire [15:0] req_wdata,
    input wire        reply_sent,
    // answer and state
    input wire        rsp_valid,
    input wire        rsp_exception,
    input wire        reply_go,
    input wire [31:0] baud_rate,
    input wire [2:0]  parity_mode,
    input wire        ascii_mode,
    input wire [7:0]  node_addr,
    input wire [7:0]  outputs,
    input wire [7:0]  output_led,
    input wire        comm_led,
    input wire        wdog_fired
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // shadow of written setup words
    // ----------------------------------------
    wire        acc = req_valid && (req_node == node_addr);
    wire        wr  = acc && (req_func == 8'h06);
    reg  [15:0] wd_q;
    reg  [15:0] to_q;
    reg  [15:0] dl_q;

    always @(posedge clk) begin
        if (rst) begin
            wd_q <= 16'h0000;
            to_q <= 16'h0000;
            dl_q <= 16'h0000;
        end else if (wr) begin
            wd_q <= req_wdata;
            to_q <= (req_ref == 17'h09C49) ? req_wdata : to_q;
            dl_q <= (req_ref == 17'h09C46) ? req_wdata : dl_q;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_RSP_TAKEN: assert property (acc |-> ##1 rsp_valid)
        else $error("accepted request got no answer");
    AST_NODE_FILTER: assert property (req_valid && req_node != node_addr |=> !rsp_valid)
        else $error("answer to a foreign node");
    AST_LED_TRACK: assert property (output_led == $past(outputs))
        else $error("output indicator off its output");
    AST_COMM_ON: assert property (reply_go |-> ##[0:1] comm_led)
        else $error("reply without comm indicator");
    AST_COMM_OFF: assert property (reply_sent && comm_led |=> !comm_led)
        else $error("comm indicator stuck after reply");
    AST_BAUD_SCALE: assert property (wr && req_ref == 17'h09C43 && req_wdata > 16'h0006
        |-> ##[1:3] baud_rate == {16'h0000, wd_q} * 32'h0000000A)
        else $error("raw rate not scaled by ten");
    AST_PARITY: assert property (wr && req_ref == 17'h09C45 && req_wdata <= 16'h0004
        |-> ##[1:3] parity_mode == wd_q[2:0])
        else $error("parity code not applied");
    AST_MODE: assert property (wr && req_ref == 17'h09C47 && req_wdata <= 16'h0001
        |-> ##[1:3] ascii_mode == wd_q[0])
        else $error("framing mode not applied");
    AST_WD_OFF: assert property (to_q == 16'h0000 && !wdog_fired |=> !wdog_fired)
        else $error("watchdog fired while disabled");
    AST_WD_RELOAD: assert property (acc |-> ##[1:3] !wdog_fired)
        else $error("watchdog not cleared by frame");
    AST_GO_PROMPT: assert property (rsp_valid && !rsp_exception && dl_q == 16'h0000
        |-> ##[1:3] reply_go)
        else $error("undelayed reply late");
    COV_REPLY: cover property (reply_go);
    COV_FIRE: cover property ($rose(wdog_fired));
    COV_EXC: cover property (rsp_valid && rsp_exception);
endmodule // modbus_slave_config_watchdog_monitor

// ### test/modbus_master_model.sv
module modbus_master_model (
    // clock
    input  wire        clk,
    // request to the slave
    output logic        req_valid,
    output logic [7:0]  req_node,
    output logic [7:0]  req_func,
    output logic [16:0] req_ref,
    output logic [15:0] req_wdata,
    output logic        reply_sent,
    // answer from the slave
    input  wire        rsp_valid,
    input  wire [15:0] rsp_rdata,
    input  wire        rsp_exception,
    input  wire        reply_go
);
    timeunit 1ns;
    timeprecision 1ns;
    int          cyc = 0;
    int          rsp_cyc = 0;
    int          go_cyc = 0;
    int          sent_cnt = 0;
    int          ack_wait = 1;
    logic        got = 1'b0;
    logic        exc = 1'b0;
    logic [15:0] rd = 16'h0000;

    initial begin
        req_valid = 1'b0;
        req_node = 8'h00;
        req_func = 8'h00;
        req_ref = 17'h00000;
        req_wdata = 16'h0000;
        reply_sent = 1'b0;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (rsp_valid === 1'b1)
            rsp_cyc <= cyc;
    end

    // ----------------------------------------
    // line engine, answers promptly or slowly
    // ----------------------------------------
    initial forever begin
        @(posedge clk);
        if (reply_go === 1'b1) begin
            go_cyc = cyc;
            repeat (ack_wait) @(posedge clk);
            #2 reply_sent = 1'b1;
            @(posedge clk);
            #2 reply_sent = 1'b0;
            sent_cnt++;
            repeat (2) @(posedge clk);
        end
    end

    // one frame; fields scrambled once released
    task automatic xfer(input logic [7:0] nd, input logic [7:0] fc, input logic [16:0] rf,
                        input logic [15:0] wd);
        int n;
        int s0;
        s0 = sent_cnt;
        got = 1'b0;
        @(posedge clk);
        #2;
        req_valid = 1'b1;
        req_node = nd;
        req_func = fc;
        req_ref = rf;
        req_wdata = wd;
        @(posedge clk);
        #2;
        req_valid = 1'b0;
        req_node = ~nd;
        req_func = ~fc;
        req_ref = ~rf;
        req_wdata = ~wd;
        for (n = 0; n < 3 && !got; n++) begin
            if (rsp_valid === 1'b1) begin
                got = 1'b1;
                rd = rsp_rdata;
                exc = rsp_exception;
            end else begin
                @(posedge clk);
                #2;
            end
        end
        for (n = 0; n < 400 && got && sent_cnt == s0; n++)
            @(posedge clk);
        #2;
    endtask
endmodule // modbus_master_model

// ### test/modbus_slave_config_watchdog_tb_top.sv
`define CHK(n, e, a) \
    begin \
        total_checks++; \
        if ((a) !== (e)) begin \
            mismatches++; \
            $display("BAD %s exp %0h got %0h", n, e, a); \
        end \
    end

module modbus_slave_config_watchdog_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int MS = 20;
    logic        clk;
    logic        rst;
    logic [4:0]  sw;
    logic        restore;
    logic [7:0]  node;
    int          cyc = 0;
    int          i;
    int          t0;
    int          mismatches = 0;
    int          total_checks = 0;
    logic [15:0] rcode [8] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h4, 16'h5, 16'h6, 16'h64};
    logic [31:0] rval [8] = '{32'd2400, 32'd4800, 32'd9600, 32'd19200, 32'd38400,
                              32'd57600, 32'd115200, 32'd1000};
    wire         req_valid, reply_sent, rsp_valid, rsp_exception, reply_go;
    wire [7:0]   req_node, req_func, node_addr, outputs, output_led;
    wire [16:0]  req_ref;
    wire [15:0]  req_wdata, rsp_rdata;
    wire [31:0]  baud_rate;
    wire [2:0]   parity_mode;
    wire         data_bits_8, stop_bits_2, ascii_mode, comm_led, wdog_fired;

    modbus_slave_config_watchdog #(.MS_CYCLES(MS)) dut_u (
        .clk, .rst,
        .addr_switch_weight_1(sw[0]), .addr_switch_weight_2(sw[1]), .addr_switch_weight_4(sw[2]),
        .addr_switch_weight_8(sw[3]), .addr_switch_weight_16(sw[4]), .factory_restore_switch(restore),
        .req_valid, .req_node, .req_func, .req_ref, .req_wdata, .frame_error(1'b0), .reply_sent,
        .rsp_valid, .rsp_rdata, .rsp_exception, .reply_go, .baud_rate, .parity_mode,
        .data_bits_8, .stop_bits_2, .ascii_mode, .node_addr, .outputs, .output_led, .comm_led,
        .wdog_fired
    );
    modbus_master_model mm_u (
        .clk, .req_valid, .req_node, .req_func, .req_ref, .req_wdata, .reply_sent,
        .rsp_valid, .rsp_rdata, .rsp_exception, .reply_go
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic do_reset();
        rst = 1'b1;
        repeat (5) @(posedge clk);
        #2 rst = 1'b0;
        repeat (10) @(posedge clk);
        #2;
    endtask

    task automatic wr(input logic [16:0] rf, input logic [15:0] v);
        mm_u.xfer(node, 8'h06, rf, v);
    endtask

    task automatic rd_chk(input string n, input logic [7:0] fc, input logic [16:0] rf, input logic [15:0] e);
        mm_u.xfer(node, fc, rf, 16'h0000);
        `CHK(n, e, mm_u.rd)
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        sw = 5'h16;
        restore = 1'b0;
        node = 8'h16;
        do_reset();
        `CHK("baud", 32'd19200, baud_rate)
        `CHK("parity", 3'h0, parity_mode)
        `CHK("data8", 1'b1, data_bits_8)
        `CHK("stop2", 1'b0, stop_bits_2)
        `CHK("ascii", 1'b0, ascii_mode)
        `CHK("node", 8'h16, node_addr)
        rd_chk("din1", 8'h02, 17'h02711, 16'h0000);
        rd_chk("din2", 8'h02, 17'h02712, 16'h0001);
        rd_chk("swword", 8'h03, 17'h07532, 16'h0016);
        mm_u.xfer(node, 8'h07, 17'h09C43, 16'h0000);
        `CHK("exc", 1'b1, mm_u.exc)
        mm_u.xfer(8'h17, 8'h04, 17'h09C43, 16'h0000);
        `CHK("foreign", 1'b0, mm_u.got)
        for (i = 0; i < 8; i++) begin
            wr(17'h09C43, rcode[i]);
            `CHK("rate", rval[i], baud_rate)
            rd_chk("rateword", 8'h04, 17'h09C43, rcode[i]);
        end
        wr(17'h09C43, 16'h0003);
        for (i = 0; i < 5; i++) begin
            wr(17'h09C45, i[15:0]);
            `CHK("par", i[2:0], parity_mode)
        end
        wr(17'h09C44, 16'h0207);
        `CHK("data7", 1'b0, data_bits_8)
        `CHK("stop2b", 1'b1, stop_bits_2)
        wr(17'h09C47, 16'h0001);
        `CHK("ascii1", 1'b1, ascii_mode)
        wr(17'h09C74, 16'h00A5);
        `CHK("outs", 8'hA5, outputs)
        `CHK("leds", 8'hA5, output_led)
        mm_u.xfer(node, 8'h05, 17'h00002, 16'h0001);
        rd_chk("coil", 8'h01, 17'h00002, 16'h0001);
        wr(17'h09C4D, 16'h003C);
        wr(17'h09C49, 16'h0003);
        wr(17'h09C74, 16'h00A5);
        t0 = mm_u.rsp_cyc;
        for (i = 0; i < 300 && wdog_fired !== 1'b1; i++)
            @(posedge clk);
        #2;
        `CHK("fired", 1'b1, wdog_fired)
        `CHK("notearly", 1'b1, (cyc - t0) >= 2 * MS)
        `CHK("forced", 8'h3C, outputs)
        wr(17'h09C49, 16'h0000);
        `CHK("rearm", 1'b0, wdog_fired)
        wr(17'h09C74, 16'h0081);
        repeat (300) @(posedge clk);
        #2;
        `CHK("wdoff", 8'h81, outputs)
        wr(17'h09C48, 16'h0040);
        node = 8'h40;
        `CHK("swnode", 8'h40, node_addr)
        rd_chk("swread", 8'h04, 17'h09C74, 16'h0081);
        mm_u.ack_wait = 6;
        wr(17'h09C46, 16'h0002);
        rd_chk("delay", 8'h04, 17'h09C46, 16'h0002);
        `CHK("latlo", 1'b1, (mm_u.go_cyc - mm_u.rsp_cyc) > MS)
        `CHK("lathi", 1'b1, (mm_u.go_cyc - mm_u.rsp_cyc) <= 2 * MS + 4)
        `CHK("commoff", 1'b0, comm_led)
        restore = 1'b1;
        node = 8'h16;
        do_reset();
        restore = 1'b0;
        `CHK("rbaud", 32'd19200, baud_rate)
        rd_chk("rrate", 8'h04, 17'h09C43, 16'h0003);
        rd_chk("rdelay", 8'h04, 17'h09C46, 16'h0000);
        rd_chk("routs", 8'h04, 17'h09C74, 16'h0000);
        `CHK("rnode", 8'h16, node_addr)
        tally_and_finish();
    end
endmodule // modbus_slave_config_watchdog_tb_top

bind modbus_slave_config_watchdog modbus_slave_config_watchdog_monitor mon_u (
    .clk, .rst, .req_valid, .req_node, .req_func, .req_ref, .req_wdata, .reply_sent,
    .rsp_valid, .rsp_exception, .reply_go, .baud_rate, .parity_mode, .ascii_mode,
    .node_addr, .outputs, .output_led, .comm_led, .wdog_fired
);
